// *** verilog/bsp_cfg.svh ***
// Constants of the burst-4 double-data-rate memory port model.
// Assumes inclusion by its bare name from the design files.
`ifndef BSP_CFG_SVH
`define BSP_CFG_SVH

// ----------------------------------------------------------------------
// Burst and organisation
// ----------------------------------------------------------------------
`define BSP_BURST_LEN 4
`define BSP_BANK_W 2
`define BSP_DATA_W_DEF 8
`define BSP_STORE_AW_DEF 4

// ----------------------------------------------------------------------
// Read path buffer and reset values
// ----------------------------------------------------------------------
`define BSP_FIFO_DEPTH 16
`define BSP_Q_RST 1'b0
`define BSP_OE_RST 1'b0

`endif

// *** verilog/bsp_pkg.sv ***
// Types shared by the memory port model.
// Assumes nothing of its surroundings.
package bsp_pkg;

  // --------------------------------------------------------------------
  // Write burst sequencer, Gray coded along the beat order
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    BSP_WR_IDLE = 2'h0,
    BSP_WR_B1 = 2'h1,
    BSP_WR_B2 = 2'h3,
    BSP_WR_B3 = 2'h2
  } bsp_wr_state_t;

  // --------------------------------------------------------------------
  // Read burst pusher
  // --------------------------------------------------------------------
  typedef enum logic {
    BSP_RD_IDLE = 1'h0,
    BSP_RD_PUSH = 1'h1
  } bsp_rd_state_t;

endpackage

// *** verilog/bsp_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_bad
      $error("bsp_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] buf_q [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] count_q;
  wire logic push;
  wire logic pop;

  assign in_ready_o = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = buf_q[rd_ptr_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // Storage needs no reset; it is read only while count is nonzero
  always_ff @(posedge clk_i) begin
    if (push) begin
      buf_q[wr_ptr_q] <= in_data_i;
    end
  end

endmodule // bsp_fifo
`default_nettype wire

// *** verilog/bsp_burst4_ddr_sram_port.sv ***
// Memory side of a separate-I/O, burst-4, double-data-rate static memory.
// Assumes all link clocks and pins are slow against clk_i (at least four
// clk_i periods per link half period) and asynchronous to it.
`timescale 1ns/1ps
`default_nettype none
`include "bsp_cfg.svh"

// Behaviour
// - On x8, two active-low nibble selects are sampled on both input clock edges.
// - Low nibble select guards data bits 3..0, high select bits 7..4.
// - Each nibble select is sampled on the same edge as its data word.
// - A deasserted nibble select leaves that stored nibble unchanged.
// - Active-low byte selects, sampled on both input edges, choose lanes written.
// - Lanes with deasserted byte select keep their stored contents.
// - One shared address bus, sampled at positive input clock rise when active.
// - Address is 19 bits for x8 and x9, 18 for x18, 17 for x36.
// - Storage is four equal arrays; one address picks one word in each.
// - Address is ignored on an edge whose owning port is deselected.
// - Read data launched on both output clock rises, or input clocks if single.
// - Read outputs go high impedance at the first positive launch edge that finds no burst word left to launch.
// - Read select, active low at positive input clock rise, starts a read.
// - Pending read finishes, then drivers float after next positive output rise, or positive input rise if single.
// - Each read returns exactly four words in sequential order.
// - Output clock pair times read data launch to deskew board flight time.
// - Inputs captured at positive input clock rise; all accesses start there.
// - Inputs also captured at negative input clock rise; it launches single-mode data.
// - Write select low at positive input rise starts a write; high ignores data.
// - Write data sampled on both input clock rises during valid writes.
module bsp_burst4_ddr_sram_port #(
  parameter int DATA_W = `BSP_DATA_W_DEF,
  parameter int STORE_AW = `BSP_STORE_AW_DEF,
  parameter int FIFO_DEPTH = `BSP_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_clk_i,
  input wire logic in_clk_n_i,
  input wire logic out_clk_i,
  input wire logic out_clk_n_i,
  input wire logic single_clk_mode_i,
  input wire logic read_port_sel_n_i,
  input wire logic write_port_sel_n_i,
  input wire logic [((DATA_W == 36) ? 17 : (DATA_W == 18) ? 18 : 19)-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic nibble_lo_write_sel_n_i,
  input wire logic nibble_hi_write_sel_n_i,
  input wire logic lane0_write_sel_n_i,
  input wire logic lane1_write_sel_n_i,
  input wire logic lane2_write_sel_n_i,
  input wire logic lane3_write_sel_n_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic rdata_oe_o
);

  // --------------------------------------------------------------------
  // Organisation
  // --------------------------------------------------------------------
  function automatic int addr_w_of(input int dw);
    case (dw)
      8: addr_w_of = 19;
      9: addr_w_of = 19;
      18: addr_w_of = 18;
      36: addr_w_of = 17;
      default: addr_w_of = 1;
    endcase
  endfunction

  function automatic int sel_w_of(input int dw);
    case (dw)
      8: sel_w_of = 2;
      9: sel_w_of = 1;
      18: sel_w_of = 2;
      36: sel_w_of = 4;
      default: sel_w_of = 1;
    endcase
  endfunction

  localparam int ADDR_W = addr_w_of(DATA_W);
  localparam int SEL_W = sel_w_of(DATA_W);
  localparam int LANE_W = DATA_W / sel_w_of(DATA_W);
  localparam int BANK_W = `BSP_BANK_W;
  localparam int MEM_N = `BSP_BURST_LEN * (1 << STORE_AW);
  localparam logic [1:0] LAST_BEAT = 2'(`BSP_BURST_LEN - 1);

  generate
    if (DATA_W != 8 && DATA_W != 9 && DATA_W != 18 && DATA_W != 36) begin : g_bad_w
      $error("bsp_burst4_ddr_sram_port: DATA_W must be 8, 9, 18 or 36");
    end
    if (STORE_AW < 1 || STORE_AW > ADDR_W) begin : g_bad_aw
      $error("bsp_burst4_ddr_sram_port: STORE_AW out of range");
    end
    if (FIFO_DEPTH < `BSP_BURST_LEN) begin : g_bad_depth
      $error("bsp_burst4_ddr_sram_port: FIFO_DEPTH below burst length");
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [3:0] clk_s1_q;
  logic [3:0] clk_s2_q;
  logic [3:0] clk_prev_q;
  logic [2:0] ctl_s1_q;
  logic [2:0] ctl_s2_q;
  logic [ADDR_W-1:0] addr_s1_q;
  logic [ADDR_W-1:0] addr_s2_q;
  logic [DATA_W-1:0] data_s1_q;
  logic [DATA_W-1:0] data_s2_q;
  logic [5:0] sel_s1_q;
  logic [5:0] sel_s2_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_s1_q <= 4'h0;
      clk_s2_q <= 4'h0;
      clk_prev_q <= 4'h0;
      ctl_s1_q <= 3'h3;
      ctl_s2_q <= 3'h3;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      data_s1_q <= '0;
      data_s2_q <= '0;
      sel_s1_q <= 6'h3F;
      sel_s2_q <= 6'h3F;
    end else begin
      clk_s1_q <= {out_clk_n_i, out_clk_i, in_clk_n_i, in_clk_i};
      clk_s2_q <= clk_s1_q;
      clk_prev_q <= clk_s2_q;
      ctl_s1_q <= {single_clk_mode_i, write_port_sel_n_i, read_port_sel_n_i};
      ctl_s2_q <= ctl_s1_q;
      addr_s1_q <= addr_i;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= wdata_i;
      data_s2_q <= data_s1_q;
      sel_s1_q <= {lane3_write_sel_n_i, lane2_write_sel_n_i, lane1_write_sel_n_i,
                   lane0_write_sel_n_i, nibble_hi_write_sel_n_i, nibble_lo_write_sel_n_i};
      sel_s2_q <= sel_s1_q;
    end
  end

  // --------------------------------------------------------------------
  // Edge detection and decoded strobes
  // --------------------------------------------------------------------
  wire logic [3:0] clk_rise;
  wire logic k_rise;
  wire logic kn_rise;
  wire logic c_rise;
  wire logic cn_rise;
  wire logic rd_sel_n;
  wire logic wr_sel_n;
  wire logic single_mode;
  wire logic [3:0] wsel_n_all;
  wire logic [SEL_W-1:0] wsel_n;

  assign clk_rise = clk_s2_q & ~clk_prev_q;
  assign k_rise = clk_rise[0];
  assign kn_rise = clk_rise[1];
  assign c_rise = clk_rise[2];
  assign cn_rise = clk_rise[3];
  assign rd_sel_n = ctl_s2_q[0];
  assign wr_sel_n = ctl_s2_q[1];
  assign single_mode = ctl_s2_q[2];
  // Nibble selects serve x8; byte selects serve the other widths
  assign wsel_n_all = (DATA_W == 8) ? {2'h3, sel_s2_q[1:0]} : sel_s2_q[5:2];
  assign wsel_n = wsel_n_all[SEL_W-1:0];

  // --------------------------------------------------------------------
  // Storage: four banks, one word of each burst beat per address
  // --------------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [0:MEM_N-1];

  function automatic logic [BANK_W+STORE_AW-1:0] mem_index(input logic [1:0] bank,
                                                           input logic [ADDR_W-1:0] addr);
    mem_index = {bank, addr[STORE_AW-1:0]};
  endfunction

  // --------------------------------------------------------------------
  // Write burst sequencer
  // --------------------------------------------------------------------
  bsp_pkg::bsp_wr_state_t wr_state_q;
  bsp_pkg::bsp_wr_state_t wr_state_d;
  logic [ADDR_W-1:0] wr_addr_q;
  wire logic wr_start;
  wire logic wr_beat;
  wire logic [1:0] wr_bank;
  wire logic [ADDR_W-1:0] wr_addr_use;

  // Write address taken only when the write port is selected
  assign wr_start = (wr_state_q == bsp_pkg::BSP_WR_IDLE) & k_rise & ~wr_sel_n;
  assign wr_beat = wr_start
                 | ((wr_state_q == bsp_pkg::BSP_WR_B1) & kn_rise)
                 | ((wr_state_q == bsp_pkg::BSP_WR_B2) & k_rise)
                 | ((wr_state_q == bsp_pkg::BSP_WR_B3) & kn_rise);
  assign wr_bank = (wr_state_q == bsp_pkg::BSP_WR_B1) ? 2'h1 :
                   (wr_state_q == bsp_pkg::BSP_WR_B2) ? 2'h2 :
                   (wr_state_q == bsp_pkg::BSP_WR_B3) ? 2'h3 : 2'h0;
  assign wr_addr_use = (wr_state_q == bsp_pkg::BSP_WR_IDLE) ? addr_s2_q : wr_addr_q;

  always_comb begin
    wr_state_d = wr_state_q;
    case (wr_state_q)
      bsp_pkg::BSP_WR_IDLE: begin
        if (wr_start) begin
          wr_state_d = bsp_pkg::BSP_WR_B1;
        end
      end
      bsp_pkg::BSP_WR_B1: begin
        if (kn_rise) begin
          wr_state_d = bsp_pkg::BSP_WR_B2;
        end
      end
      bsp_pkg::BSP_WR_B2: begin
        if (k_rise) begin
          wr_state_d = bsp_pkg::BSP_WR_B3;
        end
      end
      bsp_pkg::BSP_WR_B3: begin
        if (kn_rise) begin
          wr_state_d = bsp_pkg::BSP_WR_IDLE;
        end
      end
      default: begin
        wr_state_d = bsp_pkg::BSP_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_state_q <= bsp_pkg::BSP_WR_IDLE;
      wr_addr_q <= '0;
    end else begin
      wr_state_q <= wr_state_d;
      if (wr_start) begin
        wr_addr_q <= addr_s2_q;
      end
    end
  end

  // Per-lane write; data and selects come from the same sampled edge
  always_ff @(posedge clk_i) begin
    if (wr_beat) begin
      for (int l = 0; l < SEL_W; l++) begin
        if (!wsel_n[l]) begin
          mem_q[mem_index(wr_bank, wr_addr_use)][l*LANE_W +: LANE_W] <= data_s2_q[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Read burst pusher
  // --------------------------------------------------------------------
  bsp_pkg::bsp_rd_state_t rd_state_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [1:0] rd_beat_q;
  wire logic rd_start;
  wire logic fifo_in_ready;
  wire logic rd_push;
  wire logic [DATA_W-1:0] rd_word;

  assign rd_start = (rd_state_q == bsp_pkg::BSP_RD_IDLE) & k_rise & ~rd_sel_n;
  assign rd_push = (rd_state_q == bsp_pkg::BSP_RD_PUSH) & fifo_in_ready;
  assign rd_word = mem_q[mem_index(rd_beat_q, rd_addr_q)];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_state_q <= bsp_pkg::BSP_RD_IDLE;
      rd_addr_q <= '0;
      rd_beat_q <= 2'h0;
    end else begin
      case (rd_state_q)
        bsp_pkg::BSP_RD_IDLE: begin
          if (rd_start) begin
            rd_state_q <= bsp_pkg::BSP_RD_PUSH;
            rd_addr_q <= addr_s2_q;
            rd_beat_q <= 2'h0;
          end
        end
        bsp_pkg::BSP_RD_PUSH: begin
          if (rd_push) begin
            rd_beat_q <= rd_beat_q + 2'h1;
            if (rd_beat_q == LAST_BEAT) begin
              rd_state_q <= bsp_pkg::BSP_RD_IDLE;
            end
          end
        end
        default: begin
          rd_state_q <= bsp_pkg::BSP_RD_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Read data buffer
  // --------------------------------------------------------------------
  wire logic fifo_out_valid;
  wire logic [DATA_W-1:0] fifo_out_data;
  wire logic launch_pos;
  wire logic launch_neg;
  wire logic launch;

  // Output pair times the launch; input pair in single-clock mode
  assign launch_pos = single_mode ? k_rise : c_rise;
  assign launch_neg = single_mode ? kn_rise : cn_rise;
  assign launch = launch_pos | launch_neg;

  bsp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(rd_state_q == bsp_pkg::BSP_RD_PUSH),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rd_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(launch),
    .out_data_o(fifo_out_data)
  );

  // --------------------------------------------------------------------
  // Output drivers
  // --------------------------------------------------------------------
  logic [DATA_W-1:0] rdata_q;
  logic rdata_oe_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= {DATA_W{`BSP_Q_RST}};
      rdata_oe_q <= `BSP_OE_RST;
    end else if (launch && fifo_out_valid) begin
      rdata_q <= fifo_out_data;
      rdata_oe_q <= 1'b1;
    end else if (launch_pos) begin
      rdata_oe_q <= 1'b0;
    end
  end

  assign rdata_o = rdata_q;
  assign rdata_oe_o = rdata_oe_q;

endmodule // bsp_burst4_ddr_sram_port
`default_nettype wire

// *** test/bsp_port_sva.sv ***
// Checker of read launch timing and output enable of the memory port.
// Assumes binding to bsp_burst4_ddr_sram_port; link pins slow against clk_i.
`timescale 1ns/1ps
`default_nettype none
module bsp_port_sva #(
  parameter int DATA_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_clk_i,
  input wire logic in_clk_n_i,
  input wire logic out_clk_i,
  input wire logic out_clk_n_i,
  input wire logic single_clk_mode_i,
  input wire logic read_port_sel_n_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic rdata_oe_o
);
  // ----
  // Launch edge tracking
  // ----
  logic pos_q, neg_q, kin_q, rd_q, oe_q, last_neg_q, first_neg_q;
  logic [3:0] since_l_q, since_p_q;
  logic [2:0] n_l_q;
  wire logic pos_pin = single_clk_mode_i ? in_clk_i : out_clk_i;
  wire logic neg_pin = single_clk_mode_i ? in_clk_n_i : out_clk_n_i;
  wire logic pos_edge = pos_pin && !pos_q;
  wire logic any_edge = pos_edge || (neg_pin && !neg_q);
  // Read taken flag, cleared when a burst ends
  wire logic rd_d = (rd_q && !(oe_q && !rdata_oe_o)) || (in_clk_i && !kin_q && !read_port_sel_n_i);
  // Burst opened on a negative edge spans one extra empty edge
  wire logic last_neg_d = any_edge ? !pos_edge : last_neg_q;
  wire logic first_neg_d = (rdata_oe_o && !oe_q) ? last_neg_q : first_neg_q;
  wire logic [3:0] since_l_d = any_edge ? 4'h0 : (since_l_q == 4'hF ? 4'hF : since_l_q + 4'h1);
  wire logic [3:0] since_p_d = pos_edge ? 4'h0 : (since_p_q == 4'hF ? 4'hF : since_p_q + 4'h1);
  wire logic [2:0] n_l_d = rdata_oe_o ? n_l_q + 3'(any_edge) : 3'h0;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {pos_q, neg_q, kin_q, rd_q, oe_q, last_neg_q, first_neg_q} <= 7'h00;
      {since_l_q, since_p_q, n_l_q} <= 11'h7F8;
    end else begin
      {pos_q, neg_q, kin_q, rd_q} <= {pos_pin, neg_pin, in_clk_i, rd_d};
      {oe_q, last_neg_q, first_neg_q} <= {rdata_oe_o, last_neg_d, first_neg_d};
      {since_l_q, since_p_q, n_l_q} <= {since_l_d, since_p_d, n_l_d};
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_recent_any;
    since_l_q inside {[4'h1:4'h6]};
  endsequence
  sequence s_recent_pos;
    since_p_q inside {[4'h1:4'h6]};
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i |-> !rdata_oe_o && rdata_o == '0)
    else $error("outputs active in reset");
  a_release_quiet: assert property ($rose(rst_b_i) |-> !rdata_oe_o [*3])
    else $error("output enabled right after reset");
  a_oe_rise_launch: assert property ($rose(rdata_oe_o) |-> s_recent_any)
    else $error("output enabled without launch edge");
  a_oe_fall_pos: assert property ($fell(rdata_oe_o) |-> s_recent_pos)
    else $error("output floated without positive launch edge");
  a_word_launch: assert property ($changed(rdata_o) |-> s_recent_any)
    else $error("read word changed without launch edge");
  a_word_needs_oe: assert property ($changed(rdata_o) |-> rdata_oe_o)
    else $error("read word changed while floating");
  a_oe_needs_read: assert property ($rose(rdata_oe_o) |-> rd_q)
    else $error("output enabled with no read taken");
  a_burst_four: assert property ($fell(rdata_oe_o) |-> n_l_q == (first_neg_q ? 3'h5 : 3'h4))
    else $error("burst not four words");
endmodule // bsp_port_sva

bind bsp_burst4_ddr_sram_port bsp_port_sva #(.DATA_W(DATA_W)) u_sva (.clk_i, .rst_b_i, .in_clk_i, .in_clk_n_i,
  .out_clk_i, .out_clk_n_i, .single_clk_mode_i, .read_port_sel_n_i, .rdata_o, .rdata_oe_o);
`default_nettype wire

// *** test/bsp_host_model.sv ***
// Host controller model driving the memory port link pins.
// Assumes clk_i at 50 MHz; one link half period spans four clk_i periods.
`timescale 1ns/1ps
`default_nettype none
module bsp_host_model (
  input wire logic clk_i,
  input wire logic single_clk_mode_i,
  input wire logic [7:0] rdata_i,
  input wire logic rdata_oe_i,
  output logic in_clk_o,
  output logic in_clk_n_o,
  output logic out_clk_o,
  output logic out_clk_n_o,
  output logic read_port_sel_n_o,
  output logic write_port_sel_n_o,
  output logic [18:0] addr_o,
  output logic [7:0] wdata_o,
  output logic nibble_lo_write_sel_n_o,
  output logic nibble_hi_write_sel_n_o,
  output logic [3:0] lane_write_sel_n_o
);
  logic [7:0] got[$];
  initial begin
    {in_clk_o, in_clk_n_o, out_clk_o, out_clk_n_o} = 4'h5;
    {read_port_sel_n_o, write_port_sel_n_o} = 2'h3;
    {nibble_lo_write_sel_n_o, nibble_hi_write_sel_n_o, lane_write_sel_n_o} = 6'h3F;
    addr_o = 19'h00000;
    wdata_o = 8'h00;
  end
  // ----
  // Write burst: pins change with each input clock edge
  // ----
  task automatic wr(input logic [18:0] a, input logic [31:0] d, input logic [7:0] ns, input logic [15:0] ln,
                    input logic en);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      in_clk_o <= (i % 2 == 0);
      in_clk_n_o <= (i % 2 == 1);
      write_port_sel_n_o <= !(en && i == 0);
      addr_o <= (i == 0) ? a : ~a;
      wdata_o <= d[8*i+:8];
      nibble_lo_write_sel_n_o <= ns[2*i];
      nibble_hi_write_sel_n_o <= ns[2*i+1];
      lane_write_sel_n_o <= ln[4*i+:4];
      repeat (3) @(negedge clk_i);
    end
    @(negedge clk_i);
    wdata_o <= ~wdata_o;
  endtask
  // ----
  // Read: take edge, then launch edges; words kept while enabled
  // ----
  task automatic rd(input logic [18:0] a);
    int k;
    k = 0;
    @(negedge clk_i);
    in_clk_o <= 1'b1;
    in_clk_n_o <= 1'b0;
    read_port_sel_n_o <= 1'b0;
    addr_o <= a;
    repeat (3) @(negedge clk_i);
    for (int j = 1; j < 11; j++) begin
      @(negedge clk_i);
      if (j > 1 && rdata_oe_i === 1'b1 && k < 4) begin
        got.push_back(rdata_i);
        k++;
      end
      read_port_sel_n_o <= 1'b1;
      addr_o <= ~a;
      if (j < 10 && (j == 1 || single_clk_mode_i)) begin
        in_clk_o <= (j % 2 == 0);
        in_clk_n_o <= (j % 2 == 1);
      end else if (j < 10) begin
        out_clk_o <= (j % 2 == 0);
        out_clk_n_o <= (j % 2 == 1);
      end
      repeat (3) @(negedge clk_i);
    end
  endtask
endmodule // bsp_host_model
`default_nettype wire

// *** test/bsp_burst4_ddr_sram_port_test.sv ***
// Self-checking bench of the memory port against a behavioural memory.
// Assumes the host model drives all link pins of the port.
`timescale 1ns/1ps
`default_nettype none
module bsp_burst4_ddr_sram_port_test;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b1;
  logic single = 1'b0;
  logic in_clk, in_clk_n, out_clk, out_clk_n, rps_n, wps_n, nib_lo_n, nib_hi_n, rdata_oe;
  logic [18:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] lane_n;
  logic [7:0] mem [4][16];
  int n_errors = 0;
  int n_compared = 0;
  always #10 clk_i = ~clk_i;
  bsp_host_model host (.clk_i(clk_i), .single_clk_mode_i(single), .rdata_i(rdata), .rdata_oe_i(rdata_oe),
    .in_clk_o(in_clk), .in_clk_n_o(in_clk_n), .out_clk_o(out_clk), .out_clk_n_o(out_clk_n),
    .read_port_sel_n_o(rps_n), .write_port_sel_n_o(wps_n), .addr_o(addr), .wdata_o(wdata),
    .nibble_lo_write_sel_n_o(nib_lo_n), .nibble_hi_write_sel_n_o(nib_hi_n), .lane_write_sel_n_o(lane_n));
  bsp_burst4_ddr_sram_port uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .in_clk_i(in_clk), .in_clk_n_i(in_clk_n),
    .out_clk_i(out_clk), .out_clk_n_i(out_clk_n), .single_clk_mode_i(single), .read_port_sel_n_i(rps_n),
    .write_port_sel_n_i(wps_n), .addr_i(addr), .wdata_i(wdata), .nibble_lo_write_sel_n_i(nib_lo_n),
    .nibble_hi_write_sel_n_i(nib_hi_n), .lane0_write_sel_n_i(lane_n[0]), .lane1_write_sel_n_i(lane_n[1]),
    .lane2_write_sel_n_i(lane_n[2]), .lane3_write_sel_n_i(lane_n[3]), .rdata_o(rdata), .rdata_oe_o(rdata_oe));
  // ----
  // Checking and model tasks
  // ----
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic [3:0] a, input logic [7:0] ns, input logic en);
    logic [31:0] d;
    d = $urandom;
    host.wr({15'($urandom), a}, d, ns, 16'($urandom), en);
    for (int i = 0; i < 4; i++) begin
      if (en && !ns[2*i]) mem[i][a][3:0] = d[8*i+:4];
      if (en && !ns[2*i+1]) mem[i][a][7:4] = d[8*i+4+:4];
    end
  endtask
  task automatic get(input logic [3:0] a);
    logic [31:0] seen;
    host.got.delete();
    host.rd({15'($urandom), a});
    for (int i = 0; i < 4; i++) begin
      seen[8*i+:8] = (host.got.size() > i) ? host.got[i] : 8'hXX;
    end
    check("read burst", {mem[3][a], mem[2][a], mem[1][a], mem[0][a]}, seen);
    check("oe after burst", 32'h0, 32'(rdata_oe));
  endtask
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    // Real falling edge so the asynchronous reset acts at time zero
    rst_b_i <= 1'b0;
    void'($urandom(49));
    repeat (20) @(negedge clk_i);
    check("oe in reset", 32'h0, 32'(rdata_oe));
    check("rdata in reset", 32'h0, 32'(rdata));
    rst_b_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < 16; i++) put(4'(i), 8'h00, 1'b1);
    for (int i = 0; i < 16; i++) get(4'(i));
    for (int i = 0; i < 24; i++) begin
      put(4'(i), (i == 0) ? 8'hFF : 8'($urandom), 1'b1);
      get(4'(i));
    end
    for (int i = 0; i < 4; i++) put(4'(i), 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) get(4'(i));
    single <= 1'b1;
    repeat (8) @(negedge clk_i);
    for (int i = 4; i < 8; i++) get(4'(i));
    close_out();
  end
  initial begin
    #300us;
    n_errors++;
    close_out();
  end
endmodule // bsp_burst4_ddr_sram_port_test
`default_nettype wire
